// ===== rtl/bus_handover_pkg.sv
`default_nettype none

package bus_handover_pkg;

    // ------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam int DATA_W = 24;
    localparam int SYNC_STAGES = 3;
    localparam int STROBE_CNT = 7;
    localparam logic DEASSERTED_N = 1'b1;
    localparam logic ASSERTED_N = 1'b0;
    localparam logic OE_ON_N = 1'b0;
    localparam logic OE_OFF_N = 1'b1;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ARB_OWN,
        ARB_GRANTED,
        ARB_STALLED
    } arb_state_t;

    // Core's view of its external bus needs
    typedef struct packed {
        logic access_busy;   // External access in progress this cycle
        logic access_needed; // Next step needs the external bus
        logic dma_needed;    // Byte memory DMA wants the bus
    } core_bus_t;

    // Emulator side controls
    typedef struct packed {
        logic take_control;  // Emulator owns request/grant/reset
        logic single_step;   // Emulator is single stepping
        logic emu_halted;    // Halted in emulator space
    } emu_ctl_t;

endpackage

`default_nettype wire

// ===== rtl/external_bus_handover.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Request with bus idle: cycle after it is synchronised, float bus, assert grant, halt core.
// - Continue mode keeps executing after grant until an external access is needed.
// - Request during an access: grant waits until the cycle after it ends.
// - Grant may fall between two accesses of one instruction.
// - Request removed: drop grant, drive bus again, resume where stopped.
// - Requests honoured always, also in boot and while reset is held.
// - Stall hint asserted when core or byte DMA needs bus but it is granted.
// - Master drops request to release; grant and stall hint drop, access proceeds.
// - Emulator control swaps in emulator reset, request, grant; normal grant floats.
// - Under emulator, target reset and request ignored while stepping or halted.
module external_bus_handover #(
    parameter int ADDR_W = bus_handover_pkg::ADDR_W,
    parameter int DATA_W = bus_handover_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        sys_rst_i,
    // Bus request and reset pins
    input  wire logic                        ext_bus_req_n_i,
    input  wire logic                        emu_bus_req_n_i,
    input  wire logic                        target_reset_n_i,
    input  wire logic                        emu_reset_n_i,
    // Emulator and core status
    input  wire bus_handover_pkg::emu_ctl_t  emu_ctl_i,
    input  wire bus_handover_pkg::core_bus_t core_bus_i,
    input  wire logic                        go_mode_i,
    // Core bus values
    input  wire logic [ADDR_W-1:0]           core_addr_i,
    input  wire logic [DATA_W-1:0]           core_data_i,
    input  wire logic                        core_data_wr_i,
    input  wire logic                        prog_mem_sel_n_i,
    input  wire logic                        data_mem_sel_n_i,
    input  wire logic                        byte_mem_sel_n_i,
    input  wire logic                        combined_mem_sel_n_i,
    input  wire logic                        io_space_sel_n_i,
    input  wire logic                        rd_n_i,
    input  wire logic                        wr_n_i,
    // Bus pins toward memory
    output logic [ADDR_W-1:0]                addr_o,
    output logic                             addr_oe_n_o,
    output logic [DATA_W-1:0]                data_o,
    output logic                             data_oe_n_o,
    output logic                             prog_mem_sel_n_o,
    output logic                             data_mem_sel_n_o,
    output logic                             byte_mem_sel_n_o,
    output logic                             combined_mem_sel_n_o,
    output logic                             io_space_sel_n_o,
    output logic                             rd_n_o,
    output logic                             wr_n_o,
    output logic                             strobe_oe_n_o,
    // Grant pins
    output logic                             ext_bus_grant_n_o,
    output logic                             ext_bus_grant_oe_n_o,
    output logic                             emu_bus_grant_n_o,
    output logic                             grant_stall_hint_n_o,
    // Core controls
    output logic                             core_halt_o,
    output logic                             chip_reset_o
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic ext_req_n_s;
    logic emu_req_n_s;
    logic tgt_rst_n_s;
    logic emu_rst_n_s;

    pin_sync #(.RESET_VAL(bus_handover_pkg::DEASSERTED_N)) u_sync_ext_req (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (ext_bus_req_n_i),
        .level_o   (ext_req_n_s)
    );
    pin_sync #(.RESET_VAL(bus_handover_pkg::DEASSERTED_N)) u_sync_emu_req (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (emu_bus_req_n_i),
        .level_o   (emu_req_n_s)
    );
    pin_sync #(.RESET_VAL(bus_handover_pkg::DEASSERTED_N)) u_sync_tgt_rst (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (target_reset_n_i),
        .level_o   (tgt_rst_n_s)
    );
    pin_sync #(.RESET_VAL(bus_handover_pkg::DEASSERTED_N)) u_sync_emu_rst (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .pin_i     (emu_reset_n_i),
        .level_o   (emu_rst_n_s)
    );

    // ------------------------------------------------------------
    // Source selection
    // ------------------------------------------------------------
    wire emu_on     = emu_ctl_i.take_control;
    wire tgt_ignore = emu_ctl_i.single_step | emu_ctl_i.emu_halted;
    wire tgt_req    = ~ext_req_n_s & ~tgt_ignore;
    wire req_active = emu_on ? (~emu_req_n_s | tgt_req)
                             : ~ext_req_n_s;
    wire rst_active = emu_on ? (~emu_rst_n_s | (~tgt_rst_n_s & ~tgt_ignore))
                             : ~tgt_rst_n_s;
    wire need_bus   = core_bus_i.access_needed | core_bus_i.dma_needed;

    // ------------------------------------------------------------
    // Arbitration state machine
    // ------------------------------------------------------------
    bus_handover_pkg::arb_state_t state_ff;
    bus_handover_pkg::arb_state_t nxt_state;

    // Request state acts regardless of core reset or boot
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            bus_handover_pkg::ARB_OWN: begin
                // Grant only once no access is in flight; may land mid-instruction
                if (req_active && !core_bus_i.access_busy) begin
                    nxt_state = bus_handover_pkg::ARB_GRANTED;
                end
            end
            bus_handover_pkg::ARB_GRANTED: begin
                if (!req_active) begin
                    nxt_state = bus_handover_pkg::ARB_OWN;
                end else if (need_bus) begin
                    nxt_state = bus_handover_pkg::ARB_STALLED;
                end
            end
            bus_handover_pkg::ARB_STALLED: begin
                if (!req_active) begin
                    nxt_state = bus_handover_pkg::ARB_OWN;
                end
            end
            default: begin
                nxt_state = bus_handover_pkg::ARB_OWN;
            end
        endcase
    end

    wire nxt_granted = (nxt_state != bus_handover_pkg::ARB_OWN);
    wire nxt_stalled = (nxt_state == bus_handover_pkg::ARB_STALLED)
                     | (nxt_granted & need_bus);
    // Without continue mode the core halts as soon as the bus goes
    wire nxt_halt    = nxt_granted & (~go_mode_i | nxt_stalled);
    wire nxt_oe_n    = nxt_granted ? bus_handover_pkg::OE_OFF_N
                                   : bus_handover_pkg::OE_ON_N;
    wire nxt_grant_n = nxt_granted ? bus_handover_pkg::ASSERTED_N
                                   : bus_handover_pkg::DEASSERTED_N;

    // ------------------------------------------------------------
    // Registered outputs
    // ------------------------------------------------------------
    logic              halt_ff;
    logic              grant_n_ff;
    logic              egrant_n_ff;
    logic              grant_oe_n_ff;
    logic              hint_n_ff;
    logic              bus_oe_n_ff;
    logic              data_oe_n_ff;
    logic              rst_ff;
    logic [ADDR_W-1:0] addr_ff;
    logic [DATA_W-1:0] data_ff;
    logic [6:0]        strobes_ff;

    // Arbitration and grant pins
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_ff      <= bus_handover_pkg::ARB_OWN;
            halt_ff       <= 1'b0;
            grant_n_ff    <= bus_handover_pkg::DEASSERTED_N;
            egrant_n_ff   <= bus_handover_pkg::DEASSERTED_N;
            grant_oe_n_ff <= bus_handover_pkg::OE_ON_N;
            hint_n_ff     <= bus_handover_pkg::DEASSERTED_N;
            bus_oe_n_ff   <= bus_handover_pkg::OE_ON_N;
            rst_ff        <= 1'b1;
        end else begin
            state_ff      <= nxt_state;
            halt_ff       <= nxt_halt;
            grant_n_ff    <= emu_on ? bus_handover_pkg::DEASSERTED_N : nxt_grant_n;
            egrant_n_ff   <= emu_on ? nxt_grant_n : bus_handover_pkg::DEASSERTED_N;
            grant_oe_n_ff <= emu_on ? bus_handover_pkg::OE_OFF_N
                                    : bus_handover_pkg::OE_ON_N;
            hint_n_ff     <= nxt_stalled ? bus_handover_pkg::ASSERTED_N
                                         : bus_handover_pkg::DEASSERTED_N;
            bus_oe_n_ff   <= nxt_oe_n;
            rst_ff        <= rst_active;
        end
    end

    // Bus value registers; data driven only on writes while owned
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            addr_ff      <= '0;
            data_ff      <= '0;
            strobes_ff   <= {bus_handover_pkg::STROBE_CNT{bus_handover_pkg::DEASSERTED_N}};
            data_oe_n_ff <= bus_handover_pkg::OE_OFF_N;
        end else begin
            addr_ff      <= core_addr_i;
            data_ff      <= core_data_i;
            strobes_ff   <= {prog_mem_sel_n_i, data_mem_sel_n_i, byte_mem_sel_n_i,
                             combined_mem_sel_n_i, io_space_sel_n_i, rd_n_i, wr_n_i};
            data_oe_n_ff <= (nxt_granted | ~core_data_wr_i) ? bus_handover_pkg::OE_OFF_N
                                                             : bus_handover_pkg::OE_ON_N;
        end
    end

    assign addr_o               = addr_ff;
    assign addr_oe_n_o          = bus_oe_n_ff;
    assign data_o               = data_ff;
    assign data_oe_n_o          = data_oe_n_ff;
    assign prog_mem_sel_n_o     = strobes_ff[6];
    assign data_mem_sel_n_o     = strobes_ff[5];
    assign byte_mem_sel_n_o     = strobes_ff[4];
    assign combined_mem_sel_n_o = strobes_ff[3];
    assign io_space_sel_n_o     = strobes_ff[2];
    assign rd_n_o               = strobes_ff[1];
    assign wr_n_o               = strobes_ff[0];
    assign strobe_oe_n_o        = bus_oe_n_ff;
    assign ext_bus_grant_n_o    = grant_n_ff;
    assign ext_bus_grant_oe_n_o = grant_oe_n_ff;
    assign emu_bus_grant_n_o    = egrant_n_ff;
    assign grant_stall_hint_n_o = hint_n_ff;
    assign core_halt_o          = halt_ff;
    assign chip_reset_o         = rst_ff;

endmodule

`default_nettype wire

// ===== rtl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none

// ------------------------------------------------------------
// Three stage pin synchroniser, change accepted when last two agree
// ------------------------------------------------------------
module pin_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    // Pin and result
    input  wire logic pin_i,
    output logic      level_o
);

    logic s1_ff;
    logic s2_ff;
    logic s3_ff;
    logic level_ff;

    // Shift chain; first stage feeds only the second
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            s1_ff    <= RESET_VAL;
            s2_ff    <= RESET_VAL;
            s3_ff    <= RESET_VAL;
            level_ff <= RESET_VAL;
        end else begin
            s1_ff <= pin_i;
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
            if (s2_ff == s3_ff) begin
                level_ff <= s3_ff;
            end
        end
    end

    assign level_o = level_ff;

endmodule

`default_nettype wire

// ===== verif/bus_master_model.sv
`timescale 1ns/10ps
`default_nettype none

module bus_master_model (
    // Clock
    input  wire logic clk_i,
    // Control and grant
    input  wire logic want_i,
    input  wire logic grant_n_i,
    // Request and bus use
    output logic      req_n_o,
    output logic      drive_o
);
    initial req_n_o = 1'b1;
    // Request follows the wish; dropping it lets a stalled access go on
    always @(posedge clk_i) begin
        req_n_o <= !want_i;
    end
    // Bus taken only while grant is really low
    assign drive_o = !grant_n_i && !req_n_o;
endmodule

`default_nettype wire

// ===== verif/external_bus_handover_assertions.sv
`timescale 1ns/10ps
`default_nettype none

module external_bus_handover_checker (
    // Clock and reset
    input wire logic                        clk_i,
    input wire logic                        sys_rst_i,
    // Watched inputs
    input wire logic                        ext_bus_req_n_i,
    input wire logic                        emu_bus_req_n_i,
    input wire bus_handover_pkg::emu_ctl_t  emu_ctl_i,
    input wire bus_handover_pkg::core_bus_t core_bus_i,
    input wire logic                        go_mode_i,
    // Watched outputs
    input wire logic                        addr_oe_n_o,
    input wire logic                        data_oe_n_o,
    input wire logic                        strobe_oe_n_o,
    input wire logic                        ext_bus_grant_n_o,
    input wire logic                        ext_bus_grant_oe_n_o,
    input wire logic                        emu_bus_grant_n_o,
    input wire logic                        grant_stall_hint_n_o,
    input wire logic                        core_halt_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    wire logic need_w;
    wire logic take_w;
    wire logic step_w;
    // Shorthands for the core and emulator status
    assign need_w = core_bus_i.access_needed || core_bus_i.dma_needed;
    assign take_w = emu_ctl_i.take_control;
    assign step_w = emu_ctl_i.single_step || emu_ctl_i.emu_halted;

    idle_grant_a: assert property ((!ext_bus_req_n_i && !take_w && !core_bus_i.access_busy)[*6]
        |-> !ext_bus_grant_n_o) else $error("grant missing after idle request");
    float_granted_a: assert property ((!ext_bus_grant_n_o || !emu_bus_grant_n_o)
        |-> addr_oe_n_o && data_oe_n_o && strobe_oe_n_o) else $error("bus driven while granted");
    busy_holds_a: assert property (core_bus_i.access_busy && ext_bus_grant_n_o |=> ext_bus_grant_n_o)
        else $error("grant during access");
    release_done_a: assert property ((ext_bus_req_n_i && emu_bus_req_n_i)[*6] |-> ext_bus_grant_n_o
        && emu_bus_grant_n_o && grant_stall_hint_n_o && !addr_oe_n_o && !core_halt_o)
        else $error("bus not taken back");
    grant_float_a: assert property (1'b1 |=> ext_bus_grant_oe_n_o == $past(take_w))
        else $error("normal grant drive wrong");
    stall_hint_a: assert property ((!ext_bus_req_n_i)[*4] ##0 (!ext_bus_grant_n_o && need_w)
        |=> !grant_stall_hint_n_o && core_halt_o) else $error("stall hint missing");
    hint_granted_a: assert property (!grant_stall_hint_n_o |-> !ext_bus_grant_n_o || !emu_bus_grant_n_o)
        else $error("stall hint without grant");
    go_runs_a: assert property (go_mode_i && !need_w && grant_stall_hint_n_o |=> !core_halt_o)
        else $error("halt in continue mode");
    sync_delay_a: assert property ($fell(ext_bus_req_n_i) && ext_bus_grant_n_o
        |=> ext_bus_grant_n_o [*2]) else $error("grant before synchronising");
    emu_ignore_a: assert property ((take_w && step_w && emu_bus_req_n_i)[*6] |-> emu_bus_grant_n_o)
        else $error("target request honoured while stepping");

    // Main scenarios
    cover property (!ext_bus_grant_n_o);
    cover property (!grant_stall_hint_n_o);
    cover property (!emu_bus_grant_n_o);
endmodule

bind external_bus_handover external_bus_handover_checker u_chk (.*);

`default_nettype wire

// ===== verif/external_bus_handover_bench.sv
`timescale 1ns/10ps
`default_nettype none

module external_bus_handover_bench;
    logic                                clk_i, sys_rst_i, want, trst_n, erst_n, ereq_n, go, wr;
    logic                                req_n, drv, gnt_n, goe_n, egnt_n, hint_n, halt, crst, aoe_n, doe_n, soe_n;
    bus_handover_pkg::emu_ctl_t          ec;
    bus_handover_pkg::core_bus_t         cb;
    logic [bus_handover_pkg::ADDR_W-1:0] addr;
    logic [bus_handover_pkg::DATA_W-1:0] data;
    logic [6:0]                          strb;
    wire  [bus_handover_pkg::ADDR_W-1:0] ao;
    wire  [bus_handover_pkg::DATA_W-1:0] dout;
    wire  [6:0]                          so;
    int                                  fails, total_checks;

    bus_master_model u_mst (.clk_i(clk_i), .want_i(want), .grant_n_i(gnt_n), .req_n_o(req_n), .drive_o(drv));
    external_bus_handover u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ext_bus_req_n_i(req_n),
        .emu_bus_req_n_i(ereq_n), .target_reset_n_i(trst_n), .emu_reset_n_i(erst_n), .emu_ctl_i(ec),
        .core_bus_i(cb), .go_mode_i(go), .core_addr_i(addr), .core_data_i(data), .core_data_wr_i(wr),
        .prog_mem_sel_n_i(strb[0]), .data_mem_sel_n_i(strb[1]), .byte_mem_sel_n_i(strb[2]),
        .combined_mem_sel_n_i(strb[3]), .io_space_sel_n_i(strb[4]), .rd_n_i(strb[5]), .wr_n_i(strb[6]),
        .addr_o(ao), .addr_oe_n_o(aoe_n), .data_o(dout), .data_oe_n_o(doe_n), .prog_mem_sel_n_o(so[0]),
        .data_mem_sel_n_o(so[1]), .byte_mem_sel_n_o(so[2]), .combined_mem_sel_n_o(so[3]), .io_space_sel_n_o(so[4]),
        .rd_n_o(so[5]), .wr_n_o(so[6]), .strobe_oe_n_o(soe_n), .ext_bus_grant_n_o(gnt_n),
        .ext_bus_grant_oe_n_o(goe_n), .emu_bus_grant_n_o(egnt_n),
        .grant_stall_hint_n_o(hint_n), .core_halt_o(halt), .chip_reset_o(crst));

    // Compare and count
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Wait at falling edges for the grant level, bounded
    task automatic wait_gnt(input logic v);
        int n;
        n = 0;
        while (gnt_n !== v && n < 12) begin
            @(negedge clk_i);
            n++;
        end
    endtask

    // Grant with target reset held, normal or continue mode
    task automatic t_grant(input logic g);
        @(posedge clk_i) begin go <= g; trst_n <= 1'b0; want <= 1'b1; addr <= 14'h1a5c; wr <= 1'b1; end
        @(posedge clk_i) begin strb <= 7'h5a; data <= 24'hc3a5e1; end
        repeat (2) @(negedge clk_i);
        check("address out", ao, 14'h1a5c);
        check("data out", dout, 24'hc3a5e1);
        check("strobes out", so, 7'h5a);
        check("data driven", doe_n, 1'b0);
        wait_gnt(1'b0);
        check("grant", gnt_n, 1'b0);
        check("float", aoe_n, 1'b1);
        check("data float", doe_n, 1'b1);
        check("strobes float", soe_n, 1'b1);
        check("halt", halt, !g);
        check("chip reset", crst, 1'b1);
        @(posedge clk_i) begin want <= 1'b0; trst_n <= 1'b1; wr <= 1'b0; end
        wait_gnt(1'b1);
        check("drive again", aoe_n, 1'b0);
        check("strobes driven", soe_n, 1'b0);
        check("resume", halt, 1'b0);
        $display("test grant %0d done", g);
    endtask

    // Request during an access
    task automatic t_busy;
        @(posedge clk_i) begin go <= 1'b0; cb.access_busy <= 1'b1; want <= 1'b1; end
        repeat (10) @(negedge clk_i);
        check("grant while busy", gnt_n, 1'b1);
        @(posedge clk_i) cb.access_busy <= 1'b0;
        repeat (3) @(negedge clk_i);
        check("grant after access", gnt_n, 1'b0);
        @(posedge clk_i) want <= 1'b0;
        wait_gnt(1'b1);
        $display("test busy done");
    endtask

    // Continue mode until a core or DMA access is needed
    task automatic t_stall(input int k);
        @(posedge clk_i) begin go <= 1'b1; want <= 1'b1; end
        wait_gnt(1'b0);
        @(posedge clk_i) begin cb.access_needed <= (k == 0); cb.dma_needed <= (k == 1); end
        repeat (2) @(negedge clk_i);
        check("stall hint", hint_n, 1'b0);
        check("stall halt", halt, 1'b1);
        @(posedge clk_i) want <= 1'b0;
        wait_gnt(1'b1);
        check("hint released", hint_n, 1'b1);
        @(posedge clk_i) begin cb <= '0; go <= 1'b0; end
        $display("test stall %0d done", k);
    endtask

    // Emulator control: plain, single step, halted
    task automatic t_emu(input int k);
        @(posedge clk_i) begin ec.take_control <= 1'b1; ec.single_step <= (k == 1); ec.emu_halted <= (k == 2); end
        @(posedge clk_i) begin ereq_n <= (k != 0); want <= (k != 0); trst_n <= (k == 0); erst_n <= (k != 0); end
        repeat (10) @(negedge clk_i);
        check("normal grant float", goe_n, 1'b1);
        check("normal grant", gnt_n, 1'b1);
        check("emulator grant", egnt_n, k != 0);
        check("chip reset", crst, k == 0);
        @(posedge clk_i) begin ec <= '0; ereq_n <= 1'b1; want <= 1'b0; trst_n <= 1'b1; erst_n <= 1'b1; end
        repeat (8) @(negedge clk_i);
        check("normal grant driven", goe_n, 1'b0);
        $display("test emulator %0d done", k);
    endtask

    // Verdict and end of run
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Master never uses the bus unless it is floated
    always @(negedge clk_i) begin
        if (drv === 1'b1) check("bus float", aoe_n, 1'b1);
    end

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    initial begin
        sys_rst_i = 1'b1; want = 1'b0; trst_n = 1'b1; erst_n = 1'b1; ereq_n = 1'b1; go = 1'b0; wr = 1'b0;
        ec = '0; cb = '0; addr = '0; data = '0; strb = 7'h7f; fails = 0; total_checks = 0;
        repeat (12) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        repeat (4) @(posedge clk_i);
        t_grant(1'b0);
        t_grant(1'b1);
        t_busy;
        for (int k = 0; k < 2; k++) t_stall(k);
        for (int k = 0; k < 3; k++) t_emu(k);
        final_report;
    end

    // Watchdog against a hang
    initial begin
        #20000;
        fails++;
        final_report;
    end
endmodule

`default_nettype wire
